// ### hdl/byte_ring.sv
`timescale 1ns/1ps

// Circular byte store; pop_data is a register holding the current head
module byte_ring #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 16
) (
   input wire logic clock,
   input wire logic rst_n,
   input wire logic enable,
   ring_if.store port
);
   localparam int AW = $clog2(DEPTH);
   localparam int CW = $clog2(DEPTH + 1);

   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0] rd_ptr;
   logic [AW-1:0] wr_ptr;
   logic [CW-1:0] count;
   logic [AW-1:0] next_rd_ptr;
   logic [CW-1:0] left;

   assign port.count = count;
   assign next_rd_ptr = port.pop ? rd_ptr + 1'b1 : rd_ptr;
   assign left = port.pop ? count - 1'b1 : count;

   // Storage array, no reset needed
   always_ff @(posedge clock)
   begin
      if (enable && port.push)
         mem[wr_ptr] <= port.push_data;
   end

   // Pointers and fill level; clear beats any push or pop
   always_ff @(posedge clock or negedge rst_n)
   begin
      if (!rst_n)
      begin
         rd_ptr <= '0;
         wr_ptr <= '0;
         count <= '0;
      end
      else if (enable)
      begin
         if (port.clear)
         begin
            rd_ptr <= '0;
            wr_ptr <= '0;
            count <= '0;
         end
         else
         begin
            rd_ptr <= next_rd_ptr;
            if (port.push)
               wr_ptr <= wr_ptr + 1'b1;
            count <= left + CW'(port.push);
         end
      end
   end

   // Head register; bypass the write when the store would be empty
   always_ff @(posedge clock or negedge rst_n)
   begin
      if (!rst_n)
         port.pop_data <= '0;
      else if (enable)
      begin
         if (left == '0 && port.push)
            port.pop_data <= port.push_data;
         else
            port.pop_data <= mem[next_rd_ptr];
      end
   end
endmodule : byte_ring

// ### hdl/midi_port_irq_routing.sv
// Chosen here: the plain strobed port.
`timescale 1ns/1ps
`include "midi_port_regs.svh"

module midi_port_irq_routing #(
   parameter int DEPTH = `FIFO_DEPTH,
   parameter int BIT_CYCLES = `BIT_CYCLES,
   parameter int TIMEOUT_CYCLES = `TIMEOUT_CYCLES
) (
   input wire logic clock,
   input wire logic enable,
   input wire logic reset_n,
   input wire logic [2:0] address,
   input wire logic [7:0] write_data,
   input wire logic write_strobe,
   input wire logic read_strobe,
   output logic [7:0] read_data,
   input wire logic serial_in_pin,
   output logic serial_out_pin,
   output logic port_irq,
   output logic event_irq
);
   import midi_port_pkg::*;

   localparam int CW = $clog2(DEPTH + 1);
   localparam int RX = 0;
   localparam int TX = 1;
   localparam logic [CW-1:0] FULL_Q = CW'(DEPTH);
   localparam logic [CW-1:0] ONE_Q = CW'(1);
   localparam logic [CW-1:0] RX_LEVEL = CW'(`RX_IRQ_LEVEL);
   localparam logic [CW-1:0] TX_REFILL = CW'(`TX_IRQ_REFILL);
   localparam logic [11:0] BIT_LAST = 12'(BIT_CYCLES - 1);
   localparam logic [11:0] HALF_BIT = 12'(BIT_CYCLES / 2 - 1);
   localparam logic [16:0] TMO_LAST = 17'(TIMEOUT_CYCLES - 1);

   // ****************************************************************
   // Reply decoding
   // ****************************************************************
   function automatic reply_t pass_reply(input logic [7:0] cmd);
      reply_t r;
      r.len = 2'd2;
      r.first = `REPLY_ACK;
      case (cmd)
         8'ha0, 8'ha1, 8'ha2, 8'ha3, 8'ha4, 8'ha5, 8'ha6, 8'ha7, 8'hab:
            r.second = 8'h00;
         8'hac: r.second = 8'h15;
         8'had: r.second = 8'h01;
         8'haf: r.second = 8'h64;
         default:
         begin
            r.len = 2'd1;
            r.second = 8'h00;
         end
      endcase
      return r;
   endfunction : pass_reply

   // ****************************************************************
   // Reset release and pin synchroniser
   // ****************************************************************
   logic [1:0] rst_pipe;
   logic rst_n;
   logic [2:0] pin_sync;
   logic pin_level;

   // Two-stage release so every flop leaves reset on the same edge
   always_ff @(posedge clock or negedge reset_n)
   begin
      if (!reset_n)
         rst_pipe <= 2'b00;
      else
         rst_pipe <= {rst_pipe[0], 1'b1};
   end
   assign rst_n = rst_pipe[1];

   // Level only moves when the last two stages agree, filtering glitches
   always_ff @(posedge clock or negedge rst_n)
   begin
      if (!rst_n)
      begin
         pin_sync <= 3'b111;
         pin_level <= 1'b1;
      end
      else if (enable)
      begin
         pin_sync <= {pin_sync[1:0], serial_in_pin};
         if (pin_sync[1] == pin_sync[2])
            pin_level <= pin_sync[2];
      end
   end

   // ****************************************************************
   // Queues
   // ****************************************************************
   ring_if #(.WIDTH(8), .DEPTH(DEPTH)) ring [2] ();

   generate
      for (genvar g = 0; g < 2; g++)
      begin : queues
         byte_ring #(.WIDTH(8), .DEPTH(DEPTH)) store (
            .clock(clock),
            .rst_n(rst_n),
            .enable(enable),
            .port(ring[g])
         );
      end
   endgenerate

   logic [7:0] control;
   logic uart_mode;
   logic fifo_en;
   logic [CW-1:0] rx_count;
   logic [CW-1:0] tx_count;
   logic [CW-1:0] limit;
   logic rx_full;
   logic tx_full;

   assign fifo_en = uart_mode | control[`CTL_RX_FIFO_EN];
   assign limit = fifo_en ? FULL_Q : ONE_Q;
   assign rx_count = ring[RX].count;
   assign tx_count = ring[TX].count;
   assign rx_full = rx_count >= limit;
   assign tx_full = tx_count >= limit;

   // ****************************************************************
   // Host decode
   // ****************************************************************
   logic data_rd;
   logic data_wr;
   logic status_rd;
   logic irqs_rd;

   assign data_rd = read_strobe && address == `OFS_DATA;
   assign data_wr = write_strobe && address == `OFS_DATA;
   assign status_rd = read_strobe && address == `OFS_STATUS;
   assign irqs_rd = read_strobe && address == `OFS_IRQ_STATUS;

   // ****************************************************************
   // Serial engines
   // ****************************************************************
   rx_state_t rx_state;
   tx_state_t tx_state;
   logic [11:0] rx_cnt;
   logic [2:0] rx_bit;
   logic [7:0] rx_shift;
   logic rx_done;
   logic [11:0] tx_cnt;
   logic [3:0] tx_bits;
   logic [9:0] tx_shift;
   logic tx_line;
   logic rx_line;
   logic tx_go;

   assign tx_line = tx_shift[0];
   assign rx_line = control[`CTL_LOOPBACK] ? tx_line : pin_level;
   // Transmit only once enabled for this mode
   assign tx_go = tx_state == TX_IDLE && tx_count != '0 &&
                  (uart_mode || control[`CTL_PT_TX_EN]);

   // Receiver: mid-bit sampling, frames with bad stop bit are dropped
   always_ff @(posedge clock or negedge rst_n)
   begin
      if (!rst_n)
      begin
         rx_state <= RX_IDLE;
         rx_cnt <= '0;
         rx_bit <= '0;
         rx_shift <= '0;
         rx_done <= 1'b0;
      end
      else if (enable)
      begin
         rx_done <= 1'b0;
         if (rx_state != RX_IDLE && rx_cnt != '0)
            rx_cnt <= rx_cnt - 1'b1;
         else
            case (rx_state)
               RX_IDLE:
                  if (!rx_line)
                  begin
                     rx_state <= RX_START;
                     rx_cnt <= HALF_BIT;
                  end
               RX_START:
               begin
                  rx_state <= rx_line ? RX_IDLE : RX_DATA;
                  rx_cnt <= BIT_LAST;
                  rx_bit <= '0;
               end
               RX_DATA:
               begin
                  rx_shift <= {rx_line, rx_shift[7:1]};
                  rx_cnt <= BIT_LAST;
                  rx_bit <= rx_bit + 1'b1;
                  if (rx_bit == 3'd7)
                     rx_state <= RX_STOP;
               end
               RX_STOP:
               begin
                  rx_done <= rx_line;
                  rx_state <= RX_IDLE;
               end
               default: rx_state <= RX_IDLE;
            endcase
      end
   end

   // Transmitter: start, eight data bits LSB first, stop
   always_ff @(posedge clock or negedge rst_n)
   begin
      if (!rst_n)
      begin
         tx_state <= TX_IDLE;
         tx_cnt <= '0;
         tx_bits <= '0;
         tx_shift <= 10'h3ff;
      end
      else if (enable)
      begin
         case (tx_state)
            TX_IDLE:
               if (tx_go)
               begin
                  tx_shift <= {1'b1, ring[TX].pop_data, 1'b0};
                  tx_cnt <= BIT_LAST;
                  tx_bits <= 4'd9;
                  tx_state <= TX_SHIFT;
               end
            TX_SHIFT:
               if (tx_cnt != '0)
                  tx_cnt <= tx_cnt - 1'b1;
               else if (tx_bits == '0)
                  tx_state <= TX_IDLE;
               else
               begin
                  tx_shift <= {1'b1, tx_shift[9:1]};
                  tx_cnt <= BIT_LAST;
                  tx_bits <= tx_bits - 1'b1;
               end
            default: tx_state <= TX_IDLE;
         endcase
      end
   end

   // Pin routing; masking wins, then echo, then own transmitter
   always_ff @(posedge clock or negedge rst_n)
   begin
      if (!rst_n)
         serial_out_pin <= 1'b1;
      else if (enable)
      begin
         if (control[`CTL_PIN_MASK])
            serial_out_pin <= 1'b1;
         else if (control[`CTL_THRU])
            serial_out_pin <= pin_level;
         else
            serial_out_pin <= tx_line;
      end
   end

   // ****************************************************************
   // Commands and replies
   // ****************************************************************
   logic cmd_pending;
   logic [7:0] cmd_byte;
   logic cmd_exec;
   logic port_reset;
   logic enter_uart;
   logic [1:0] resp_left;
   logic [7:0] resp_head;
   logic [7:0] resp_tail;
   logic resp_push;
   logic overrun;
   reply_t reply;

   // Commands wait for any byte already on the wire to finish
   assign cmd_exec = cmd_pending && tx_state == TX_IDLE && !tx_go &&
                     rx_state == RX_IDLE && !rx_done;
   assign reply = pass_reply(cmd_byte);
   assign port_reset = cmd_exec && cmd_byte == `CMD_RESET;
   assign enter_uart = cmd_exec && !uart_mode && cmd_byte == `CMD_UART;
   // Replies take the queue only when the engine is not storing
   assign resp_push = resp_left != '0 && !rx_done && !rx_full;

   always_ff @(posedge clock or negedge rst_n)
   begin
      if (!rst_n)
      begin
         cmd_pending <= 1'b0;
         cmd_byte <= '0;
         uart_mode <= 1'b0;
         resp_left <= '0;
         resp_head <= '0;
         resp_tail <= '0;
      end
      else if (enable)
      begin
         if (write_strobe && address == `OFS_STATUS)
         begin
            cmd_pending <= 1'b1;
            cmd_byte <= write_data;
         end
         else if (cmd_exec)
            cmd_pending <= 1'b0;
         if (resp_push)
         begin
            resp_left <= resp_left - 1'b1;
            resp_head <= resp_tail;
         end
         if (port_reset)
            uart_mode <= 1'b0;
         else if (enter_uart)
            uart_mode <= 1'b1;
         // UART mode ignores everything but reset and sends no reply
         if (cmd_exec && !uart_mode)
         begin
            resp_left <= reply.len;
            resp_head <= reply.first;
            resp_tail <= reply.second;
         end
      end
   end

   // Queue strobes; a clear beats the pushes in the store
   always_comb
   begin
      ring[RX].clear = port_reset ||
                       (enter_uart && !control[`CTL_RX_FIFO_EN]);
      ring[TX].clear = port_reset;
      ring[RX].push = resp_push || (rx_done && !rx_full);
      ring[RX].push_data = resp_push ? resp_head : rx_shift;
      ring[RX].pop = data_rd && rx_count != '0;
      ring[TX].push = data_wr && !tx_full;
      ring[TX].push_data = write_data;
      ring[TX].pop = tx_go;
   end

   // Overrun is sticky until status read or reset command; a new overrun beats both
   always_ff @(posedge clock or negedge rst_n)
   begin
      if (!rst_n)
         overrun <= 1'b0;
      else if (enable)
      begin
         if (rx_done && rx_full)
            overrun <= 1'b1;
         else if (status_rd || port_reset)
            overrun <= 1'b0;
      end
   end

   // ****************************************************************
   // Interrupt requests
   // ****************************************************************
   logic [16:0] tmo_cnt;
   logic timeout;
   logic tx_hold;
   logic rx_req;
   logic tx_req;
   logic tmo_restart;

   assign tmo_restart = rx_done || ring[RX].pop;

   // Idle timer only runs while the deep queue holds data
   always_ff @(posedge clock or negedge rst_n)
   begin
      if (!rst_n)
      begin
         tmo_cnt <= '0;
         timeout <= 1'b0;
      end
      else if (enable)
      begin
         if (tmo_restart || !fifo_en || rx_count == '0 || port_reset)
         begin
            tmo_cnt <= '0;
            timeout <= 1'b0;
         end
         else if (tmo_cnt == TMO_LAST)
            timeout <= 1'b1;
         else
            tmo_cnt <= tmo_cnt + 1'b1;
      end
   end

   // Transmit request in queue mode has hysteresis, empty to three
   always_ff @(posedge clock or negedge rst_n)
   begin
      if (!rst_n)
         tx_hold <= 1'b1;
      else if (enable)
      begin
         if (tx_count == '0)
            tx_hold <= 1'b1;
         else if (tx_count >= TX_REFILL)
            tx_hold <= 1'b0;
      end
   end

   always_comb
   begin
      if (fifo_en)
         rx_req = rx_count >= RX_LEVEL || timeout;
      else
         rx_req = rx_count != '0;
      if (fifo_en)
         tx_req = tx_hold;
      else
         tx_req = tx_count == '0;
   end

   // ****************************************************************
   // Registers and read port
   // ****************************************************************
   logic [2:0] irq_status;
   logic [2:0] irq_mask;
   logic [2:0] events;
   logic rx_req_d;
   logic tx_req_d;
   logic [7:0] status_byte;

   assign events = {rx_done && rx_full, tx_req && !tx_req_d,
                    rx_req && !rx_req_d};

   always_comb
   begin
      status_byte = 8'h00;
      status_byte[`STA_RX_EMPTY] = rx_count == '0;
      status_byte[`STA_TX_FULL] = tx_full;
      status_byte[`STA_RX_FULL] = fifo_en && rx_count >= FULL_Q;
      status_byte[`STA_UART_MODE] = uart_mode;
      status_byte[`STA_OVERRUN] = overrun;
      status_byte[`STA_TX_NOT_EMPTY] = fifo_en && tx_count != '0;
   end

   // Control and mask; reset enables only receive requests
   always_ff @(posedge clock or negedge rst_n)
   begin
      if (!rst_n)
      begin
         control <= `CTL_RESET;
         irq_mask <= `MASK_RESET;
      end
      else if (enable && write_strobe)
      begin
         if (address == `OFS_CONTROL)
            control <= write_data & `CTL_WRITABLE;
         if (address == `OFS_IRQ_MASK)
            irq_mask <= write_data[2:0];
      end
   end

   // Sticky events; reading clears, but a same-cycle event survives
   always_ff @(posedge clock or negedge rst_n)
   begin
      if (!rst_n)
      begin
         irq_status <= `EVT_RESET;
         rx_req_d <= 1'b0;
         tx_req_d <= 1'b1; // Empty at reset, so no false event
      end
      else if (enable)
      begin
         rx_req_d <= rx_req;
         tx_req_d <= tx_req;
         irq_status <= (irqs_rd ? 3'h0 : irq_status) | events;
      end
   end

   // Outputs; transmit requests gated by bit 1, receive by bit 3
   always_ff @(posedge clock or negedge rst_n)
   begin
      if (!rst_n)
      begin
         port_irq <= 1'b0;
         event_irq <= 1'b0;
      end
      else if (enable)
      begin
         port_irq <= (control[`CTL_RX_IRQ_EN] && rx_req) ||
                     (control[`CTL_TX_IRQ_EN] && tx_req);
         event_irq <= |(irq_status & irq_mask);
      end
   end

   // Read data stand one cycle after the strobe; unmapped reads zero
   always_ff @(posedge clock or negedge rst_n)
   begin
      if (!rst_n)
         read_data <= 8'h00;
      else if (enable)
      begin
         if (read_strobe)
            case (address)
               `OFS_DATA: read_data <= ring[RX].pop_data;
               `OFS_STATUS: read_data <= status_byte;
               `OFS_CONTROL: read_data <= control;
               `OFS_IRQ_STATUS: read_data <= {5'h00, irq_status};
               `OFS_IRQ_MASK: read_data <= {5'h00, irq_mask};
               default: read_data <= 8'h00;
            endcase
         else
            read_data <= 8'h00;
      end
   end
endmodule : midi_port_irq_routing

// ### hdl/midi_port_pkg.sv
package midi_port_pkg;

   typedef enum logic [1:0] {
      RX_IDLE = 2'b00,
      RX_START = 2'b01,
      RX_DATA = 2'b10,
      RX_STOP = 2'b11
   } rx_state_t;

   typedef enum logic {
      TX_IDLE = 1'b0,
      TX_SHIFT = 1'b1
   } tx_state_t;

   typedef struct packed {
      logic [1:0] len;
      logic [7:0] first;
      logic [7:0] second;
   } reply_t;

endpackage : midi_port_pkg

// ### hdl/midi_port_regs.svh
`ifndef MIDI_PORT_REGS_SVH
`define MIDI_PORT_REGS_SVH

// Register offsets
`define OFS_DATA 3'h0
`define OFS_STATUS 3'h1
`define OFS_CONTROL 3'h2
`define OFS_IRQ_STATUS 3'h3
`define OFS_IRQ_MASK 3'h4

// Feature control bits
`define CTL_RX_FIFO_EN 0
`define CTL_TX_IRQ_EN 1
`define CTL_PIN_MASK 2
`define CTL_RX_IRQ_EN 3
`define CTL_PT_TX_EN 4
`define CTL_THRU 6
`define CTL_LOOPBACK 7
`define CTL_RESET 8'h08
`define CTL_WRITABLE 8'hdf

// Port status bits
`define STA_RX_EMPTY 7
`define STA_TX_FULL 6
`define STA_RX_FULL 5
`define STA_UART_MODE 4
`define STA_OVERRUN 3
`define STA_TX_NOT_EMPTY 2

// Sticky event bits
`define EVT_RX 0
`define EVT_TX 1
`define EVT_OVR 2
`define EVT_RESET 3'h0
`define MASK_RESET 3'h0

// Commands and replies
`define CMD_UART 8'h3f
`define CMD_RESET 8'hff
`define REPLY_ACK 8'hfe

// Queue figures
`define FIFO_DEPTH 16
`define RX_IRQ_LEVEL 8
`define TX_IRQ_REFILL 3

// Timing
`define CLOCK_PERIOD_NS 10
`define MIDI_BIT_NS 32000
`define RX_TIMEOUT_NS 1280000
`define BIT_CYCLES (`MIDI_BIT_NS / `CLOCK_PERIOD_NS)
`define TIMEOUT_CYCLES (`RX_TIMEOUT_NS / `CLOCK_PERIOD_NS)

`endif

// ### hdl/ring_if.sv
`timescale 1ns/1ps

interface ring_if #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 16
);
   localparam int CW = $clog2(DEPTH + 1);
   logic push;
   logic pop;
   logic clear;
   logic [WIDTH-1:0] push_data;
   logic [WIDTH-1:0] pop_data;
   logic [CW-1:0] count;

   modport owner (output push, output pop, output clear, output push_data,
                  input pop_data, input count);
   modport store (input push, input pop, input clear, input push_data,
                  output pop_data, output count);
endinterface : ring_if

// ### tb/midi_instrument.sv
`timescale 1ns/1ps
// ****************
// Far-end instrument
// ****************
module midi_instrument #(
   parameter int BIT = 16
) (
   input wire logic clock,
   input wire logic listen,
   output logic line
);
   logic [7:0] heard[$];
   logic [7:0] got;
   logic [9:0] frame;
   initial line = 1'b1;
   // Start, data LSB first, stop; gap lets the far end be slow
   task automatic send(input logic [7:0] b, input int gap);
      frame = {1'b1, b, 1'b0};
      for (int k = 0; k < 10; k++)
      begin
         line <= frame[k];
         repeat (BIT) @(posedge clock);
      end
      repeat (gap) @(posedge clock);
   endtask : send
   // Mid-bit sampling; a frame with a low stop bit is thrown away
   initial
   begin
      forever
      begin
         @(negedge listen);
         repeat (BIT / 2) @(posedge clock);
         for (int i = 0; i < 8; i++)
         begin
            repeat (BIT) @(posedge clock);
            got[i] = listen;
         end
         repeat (BIT) @(posedge clock);
         if (listen === 1'b1) heard.push_back(got);
      end
   end
endmodule : midi_instrument

// ### tb/midi_port_irq_routing_sva.sv
`timescale 1ns/1ps
// ****************
// Port checker
// ****************
module midi_port_sva (
   input wire logic clock,
   input wire logic enable,
   input wire logic reset_n,
   input wire logic [2:0] address,
   input wire logic [7:0] write_data,
   input wire logic write_strobe,
   input wire logic read_strobe,
   input wire logic [7:0] read_data,
   input wire logic serial_in_pin,
   input wire logic serial_out_pin,
   input wire logic port_irq,
   input wire logic event_irq
);
   logic [7:0] ctl;
   logic [7:0] ctl_d;
   logic [2:0] mask;
   logic [2:0] mask_d;
   default clocking @(posedge clock); endclocking
   default disable iff (!reset_n);
   // Shadow of what software last wrote to control and mask
   always_ff @(posedge clock or negedge reset_n)
   begin
      if (!reset_n)
      begin
         ctl <= 8'h08;
         mask <= 3'h0;
      end
      else if (enable && write_strobe && address == 3'h2)
         ctl <= write_data;
      else if (enable && write_strobe && address == 3'h4)
         mask <= write_data[2:0];
   end
   // Outputs are registered, so they follow the shadow one cycle late
   always_ff @(posedge clock)
   begin
      ctl_d <= ctl;
      mask_d <= mask;
   end
   a_read_idle: assert property (
      enable && !read_strobe |=> read_data == 8'h00)
      else $error("read data not zero outside a read");
   a_unmapped_zero: assert property (
      enable && read_strobe && address > 3'h4 |=> read_data == 8'h00)
      else $error("unmapped offset returned data");
   a_status_low: assert property (
      enable && read_strobe && address == 3'h1 |=> read_data[1:0] == 2'b00)
      else $error("status low bits not zero");
   a_ctl_readback: assert property (
      enable && read_strobe && address == 3'h2
      |=> read_data == (ctl_d & 8'hdf))
      else $error("control readback wrong");
   a_pin_masked: assert property (
      ctl[2] && ctl_d[2] |-> serial_out_pin)
      else $error("masked pin not high");
   a_irq_quiet: assert property (
      !ctl[1] && !ctl[3] && !ctl_d[1] && !ctl_d[3] |-> !port_irq)
      else $error("request with both sources disabled");
   a_event_masked: assert property (
      mask == 3'h0 && mask_d == 3'h0 |-> !event_irq)
      else $error("event request while fully masked");
   a_thru_echo: assert property (
      (ctl[6] && !ctl[2] && $stable(serial_in_pin))[*8]
      |-> serial_out_pin == serial_in_pin)
      else $error("thru echo does not follow input");
   c_uart: cover property (write_strobe && address == 3'h1 && write_data == 8'h3f);
   c_irq: cover property ($rose(port_irq));
   c_event: cover property ($rose(event_irq));
endmodule : midi_port_sva

bind midi_port_irq_routing midi_port_sva i_sva (.clock(clock), .enable(enable),
   .reset_n(reset_n), .address(address), .write_data(write_data),
   .write_strobe(write_strobe), .read_strobe(read_strobe),
   .read_data(read_data), .serial_in_pin(serial_in_pin),
   .serial_out_pin(serial_out_pin), .port_irq(port_irq),
   .event_irq(event_irq));

// ### tb/midi_port_irq_routing_tb.sv
`timescale 1ns/1ps
module midi_port_irq_routing_tb;
   logic clock, enable, reset_n, write_strobe, read_strobe, rd_d;
   logic [2:0] address;
   logic [7:0] write_data, read_data, b, e;
   logic serial_out_pin, port_irq, event_irq, line;
   logic [7:0] expq[$];
   int fails, comparisons, n;
   midi_port_irq_routing #(.BIT_CYCLES(16), .TIMEOUT_CYCLES(640)) i_dut (
      .clock(clock), .enable(enable), .reset_n(reset_n),
      .address(address), .write_data(write_data),
      .write_strobe(write_strobe), .read_strobe(read_strobe),
      .read_data(read_data), .serial_in_pin(line),
      .serial_out_pin(serial_out_pin), .port_irq(port_irq),
      .event_irq(event_irq));
   midi_instrument #(.BIT(16)) i_far (.clock(clock),
      .listen(serial_out_pin), .line(line));
   task automatic check(input string what, input logic [7:0] seen,
                        input logic [7:0] exp);
      comparisons++;
      if (seen !== exp)
      begin
         fails++;
         $display("unexpected %s: expected %h, seen %h", what, exp, seen);
      end
   endtask : check
   task automatic print_verdict();
      $display("comparisons %0d, fails %0d", comparisons, fails);
      if (fails == 0 && comparisons > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask : print_verdict
   // Strobes drop for a cycle between calls, so no signal is set twice
   task automatic wr(input logic [2:0] a, input logic [7:0] d);
      write_strobe <= 1'b1;
      address <= a;
      write_data <= d;
      @(posedge clock);
      write_strobe <= 1'b0;
      @(posedge clock);
   endtask : wr
   task automatic rd(input logic [2:0] a, input logic [7:0] x);
      read_strobe <= 1'b1;
      address <= a;
      expq.push_back(x);
      @(posedge clock);
      read_strobe <= 1'b0;
      @(posedge clock);
   endtask : rd
   task automatic wait_irq(input logic v, input int lim);
      n = 0;
      while (port_irq !== v && n < lim)
      begin
         @(posedge clock);
         n++;
      end
      if (port_irq !== v)
      begin
         fails++;
         $display("unexpected port_irq: expected %b, seen %b", v, port_irq);
         print_verdict();
      end
   endtask : wait_irq
   function automatic logic [7:0] far_byte();
      return i_far.heard.size() > 0 ? i_far.heard.pop_front() : 8'hxx;
   endfunction : far_byte
   // ****************
   // Clock, monitor, sequence
   // ****************
   initial
   begin
      clock = 1'b0;
      forever #5 clock = ~clock;
   end
   // Read data stands only in the cycle after the strobe
   always @(posedge clock)
   begin
      if (rd_d)
      begin
         e = expq.pop_front();
         check("read data", read_data, e);
      end
      rd_d <= read_strobe;
   end
   initial
   begin
      {enable, reset_n, write_strobe, read_strobe, rd_d} = 5'b10000;
      address = 3'h0;
      write_data = 8'h00;
      fails = 0;
      comparisons = 0;
      n = $urandom(32'ha46c67bc);
      repeat (10) @(posedge clock);
      reset_n <= 1'b1;
      repeat (3) @(posedge clock);
      rd(3'h1, 8'h80);
      rd(3'h2, 8'h08);
      rd(3'h5, 8'h00);
      $display("test reset done");
      b = 8'($urandom);
      wr(3'h2, 8'h48);
      i_far.send(b, 20);
      check("echo", far_byte(), b);
      wait_irq(1'b1, 50);
      rd(3'h0, b);
      wait_irq(1'b0, 4);
      $display("test thru done");
      wr(3'h2, 8'h0a);
      wait_irq(1'b1, 10);
      b = 8'($urandom);
      wr(3'h0, b);
      wait_irq(1'b0, 5);
      repeat (200) @(posedge clock);
      check("idle far end", 8'(i_far.heard.size()), 8'h00);
      wr(3'h2, 8'h1a);
      repeat (200) @(posedge clock);
      check("tx byte", far_byte(), b);
      wait_irq(1'b1, 10);
      $display("test transmit done");
      wr(3'h1, 8'h3f);
      repeat (4) @(posedge clock);
      rd(3'h0, 8'hfe);
      rd(3'h1, 8'h90);
      wr(3'h2, 8'h8c);
      // Receive rise in thru test and transmit rise after sending
      rd(3'h3, 8'h03);
      wr(3'h4, 8'h01);
      for (int i = 0; i < 8; i++)
         wr(3'h0, 8'h30 + 8'(i));
      wait_irq(1'b1, 2000);
      repeat (3) @(posedge clock);
      check("event request", 8'(event_irq), 8'h01);
      rd(3'h3, 8'h03);
      rd(3'h0, 8'h30);
      wait_irq(1'b0, 4);
      wait_irq(1'b1, 700);
      check("timeout", 8'(n > 600 && n < 660), 8'h01);
      rd(3'h0, 8'h31);
      wait_irq(1'b0, 4);
      for (int i = 2; i < 8; i++)
         rd(3'h0, 8'h30 + 8'(i));
      rd(3'h1, 8'h90);
      $display("test queue done");
      wr(3'h2, 8'h84);
      wr(3'h0, 8'h55);
      repeat (900) @(posedge clock);
      check("rx request off", 8'(port_irq), 8'h00);
      wr(3'h1, 8'hff);
      repeat (4) @(posedge clock);
      // Two-byte reply waits in the single buffer behind the ack
      wr(3'h1, 8'hac);
      repeat (4) @(posedge clock);
      rd(3'h0, 8'hfe);
      rd(3'h0, 8'h15);
      rd(3'h1, 8'h80);
      $display("test reset command done");
      repeat (4) @(posedge clock);
      print_verdict();
   end
endmodule : midi_port_irq_routing_tb
